// ### include/tws_pkg.sv
// Package with constants for the timed write sequencer.
package tws_pkg;
  localparam int TWS_QUEUE_BYTES = 512;
  localparam int TWS_DATA_W = 8;
  localparam int TWS_ADDR_W = 8;
  localparam int TWS_TICK_NS = 1000;
  localparam int TWS_CLK_NS = 50;
  localparam int TWS_TICK_CYC = (TWS_TICK_NS + TWS_CLK_NS - 1) / TWS_CLK_NS;
  localparam int TWS_CREG_COUNT = 256;
  localparam logic [7:0] TWS_CREG_RESET = 8'h00;
  localparam logic [7:0] TWS_TIMER_RESET = 8'h00;
  typedef enum logic [1:0] {
    TWS_ST_TIMER = 2'b00,
    TWS_ST_ADDR = 2'b01,
    TWS_ST_DATA = 2'b10,
    TWS_ST_WAIT = 2'b11
  } tws_state_t;
endpackage

// ### src/tws_skid.sv
// Two-entry buffer with valid and ready on both sides.
`timescale 1ns/1ps
module tws_skid #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  // Filling side
  input wire logic i_valid,
  output logic o_ready,
  input wire logic [WIDTH-1:0] i_data,
  // Draining side
  output logic o_valid,
  input wire logic i_ready,
  output logic [WIDTH-1:0] o_data
);
  logic [WIDTH-1:0] mem_reg [2];
  logic rd_reg;
  logic wr_reg;
  logic [1:0] cnt_reg;
  logic push;
  logic pop;

  if (WIDTH < 1) begin : g_bad_width
    $error("tws_skid WIDTH must be positive");
  end

  assign o_ready = (cnt_reg != 2'd2);
  assign o_valid = (cnt_reg != 2'd0);
  assign o_data = mem_reg[rd_reg];
  assign push = i_valid && o_ready;
  assign pop = o_valid && i_ready;

  always_ff @(posedge i_ref_clk) begin
    if (push) begin
      mem_reg[wr_reg] <= i_data;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      rd_reg <= 1'b0;
      wr_reg <= 1'b0;
      cnt_reg <= 2'd0;
    end else begin
      if (push) wr_reg <= ~wr_reg;
      if (pop) rd_reg <= ~rd_reg;
      if (push && !pop) cnt_reg <= cnt_reg + 2'd1;
      else if (pop && !push) cnt_reg <= cnt_reg - 2'd1;
    end
  end
endmodule

// ### src/tws_top.sv
// Timed write sequencer: byte queue, record parser, timer and control registers.
// Notes on behaviour
// RULE1: A 512-byte queue returns bytes strictly in the order they were written.
// RULE2: The host loads the queue only through the interface write port, and every byte is kept.
// RULE3: Each record is a timer byte, then a register address byte, then a data byte.
// RULE4: A record is dequeued, its interval is waited out, and only then is the data written.
// RULE5: Control registers also take immediate host writes and answer host reads.
// RULE6: The power-on reset and the active-low reset pin clear the registers in the same way.
// RULE7: The host leaves enough idle time after a read address before fetching read data.
// RULE8: With no complete record queued the sequencer stays idle and writes nothing.
`timescale 1ns/1ps
module tws_top
  import tws_pkg::*;
#(
  parameter int DEPTH = tws_pkg::TWS_QUEUE_BYTES,
  parameter int TICK_CYC = tws_pkg::TWS_TICK_CYC
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  input wire logic i_por,
  // Queue load from the interface register
  input wire logic i_q_valid,
  input wire logic [tws_pkg::TWS_DATA_W-1:0] i_q_data,
  output logic o_q_ready,
  // Immediate control register access
  input wire logic i_cr_wr,
  input wire logic i_cr_rd,
  input wire logic [tws_pkg::TWS_ADDR_W-1:0] i_cr_addr,
  input wire logic [tws_pkg::TWS_DATA_W-1:0] i_cr_wdata,
  output logic [tws_pkg::TWS_DATA_W-1:0] o_cr_rdata,
  output logic o_cr_rvalid,
  // Status
  output logic o_q_empty,
  output logic o_seq_busy,
  // Control register write stream toward the synthesizer
  output logic o_sw_valid,
  input wire logic i_sw_ready,
  output logic [tws_pkg::TWS_ADDR_W-1:0] o_sw_addr,
  output logic [tws_pkg::TWS_DATA_W-1:0] o_sw_data
);
  import tws_pkg::*;

  localparam int PW = $clog2(DEPTH);
  localparam int SW = TWS_ADDR_W + TWS_DATA_W;

  // Pointers wrap by overflow, so only power-of-two depths keep the byte order intact.
  if (DEPTH < 4 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("DEPTH must be a power of two");
  end
  if (TICK_CYC < 1) begin : g_bad_tick
    $error("TICK_CYC must be at least one");
  end

  // Both reset sources act as one, so the power-on path cannot differ from the pin.
  logic rst_n;
  assign rst_n = i_nrst && !i_por; // see RULE6

  // The count has one extra bit so that a full queue differs from an empty one.
  logic [TWS_DATA_W-1:0] q_mem [DEPTH];
  logic [PW-1:0] q_wp_reg;
  logic [PW-1:0] q_rp_reg;
  logic [PW:0] q_cnt_reg;
  logic q_push;
  logic q_pop;
  logic [TWS_DATA_W-1:0] q_head;

  assign o_q_ready = (q_cnt_reg != (PW+1)'(DEPTH)); // see RULE2
  assign q_push = i_q_valid && o_q_ready; // see RULE2
  assign q_head = q_mem[q_rp_reg];
  assign o_q_empty = (q_cnt_reg == '0);

  always_ff @(posedge i_ref_clk) begin
    if (q_push) begin
      q_mem[q_wp_reg] <= i_q_data; // see RULE1
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!rst_n) begin
      q_wp_reg <= '0;
      q_rp_reg <= '0;
      q_cnt_reg <= '0;
    end else begin
      if (q_push) q_wp_reg <= q_wp_reg + PW'(1); // see RULE1
      if (q_pop) q_rp_reg <= q_rp_reg + PW'(1); // see RULE1
      if (q_push && !q_pop) q_cnt_reg <= q_cnt_reg + (PW+1)'(1);
      else if (q_pop && !q_push) q_cnt_reg <= q_cnt_reg - (PW+1)'(1);
    end
  end

  // Sequencer: a record is taken whole so a half-loaded record never starts a wait.
  tws_state_t state_reg;
  logic [TWS_DATA_W-1:0] timer_reg;
  logic [TWS_ADDR_W-1:0] addr_reg;
  logic [TWS_DATA_W-1:0] data_reg;
  logic [$clog2(TICK_CYC+1)-1:0] tick_reg;
  logic tick;
  logic rec_ready;
  logic sk_ready;
  logic sk_valid;
  logic [SW-1:0] sk_out;
  logic seq_fire;

  // True in the two states that take the address and data bytes of a record.
  function automatic logic in_parse(input tws_state_t s);
    return (s == TWS_ST_ADDR) || (s == TWS_ST_DATA);
  endfunction

  assign rec_ready = (q_cnt_reg >= (PW+1)'(3)); // see RULE8
  assign q_pop = (state_reg == TWS_ST_TIMER && rec_ready) || in_parse(state_reg); // see RULE3
  assign tick = (tick_reg == '0);
  assign seq_fire = (state_reg == TWS_ST_WAIT) && (timer_reg == '0) && sk_ready; // see RULE4
  assign o_seq_busy = (state_reg != TWS_ST_TIMER);

  // The divider reloads outside the wait, so every interval starts with a full tick period.
  always_ff @(posedge i_ref_clk) begin
    if (!rst_n) begin
      tick_reg <= '0;
    end else if (state_reg != TWS_ST_WAIT || tick) begin
      tick_reg <= ($clog2(TICK_CYC+1))'(TICK_CYC - 1);
    end else begin
      tick_reg <= tick_reg - 1'b1;
    end
  end

  // The address and data pops are unconditional, which is safe because three bytes were counted.
  always_ff @(posedge i_ref_clk) begin
    if (!rst_n) begin
      state_reg <= TWS_ST_TIMER;
      timer_reg <= TWS_TIMER_RESET;
      addr_reg <= '0;
      data_reg <= '0;
    end else begin
      case (state_reg)
        TWS_ST_TIMER: begin
          if (rec_ready) begin // see RULE8
            timer_reg <= q_head; // see RULE3
            state_reg <= TWS_ST_ADDR;
          end
        end
        TWS_ST_ADDR: begin
          addr_reg <= q_head; // see RULE3
          state_reg <= TWS_ST_DATA;
        end
        TWS_ST_DATA: begin
          data_reg <= q_head; // see RULE3
          state_reg <= TWS_ST_WAIT;
        end
        TWS_ST_WAIT: begin
          if (timer_reg != '0) begin
            if (tick && state_reg == TWS_ST_WAIT) timer_reg <= timer_reg - 8'h01; // see RULE4
          end else if (seq_fire) begin
            state_reg <= TWS_ST_TIMER;
          end
        end
        default: state_reg <= TWS_ST_TIMER;
      endcase
    end
  end

  // Control registers; a host write in the same cycle as a timed write wins.
  logic [TWS_DATA_W-1:0] creg [TWS_CREG_COUNT];
  logic seq_wr;
  assign seq_wr = seq_fire;

  // Reset clears every register, so a power-on and a pin reset leave the same contents.
  always_ff @(posedge i_ref_clk) begin
    if (!rst_n) begin
      for (int i = 0; i < TWS_CREG_COUNT; i++) begin
        creg[i] <= TWS_CREG_RESET; // see RULE6
      end
    end else begin
      if (seq_wr) creg[addr_reg] <= data_reg; // see RULE4
      if (i_cr_wr) creg[i_cr_addr] <= i_cr_wdata; // see RULE5
    end
  end

  // Read data holds until the next read; a read beside a write to one address sees the old value.
  always_ff @(posedge i_ref_clk) begin
    if (!rst_n) begin
      o_cr_rdata <= '0;
      o_cr_rvalid <= 1'b0;
    end else begin
      o_cr_rvalid <= i_cr_rd; // see RULE5
      if (i_cr_rd) o_cr_rdata <= creg[i_cr_addr]; // see RULE5
    end
  end

  // Timed writes also leave through a buffer so a stalled receiver drops nothing.
  tws_skid #(
    .WIDTH(SW)
  ) u_skid (
    .i_ref_clk(i_ref_clk),
    .i_nrst(rst_n),
    .i_valid(seq_fire),
    .o_ready(sk_ready),
    .i_data({addr_reg, data_reg}),
    .o_valid(sk_valid),
    .i_ready(i_sw_ready),
    .o_data(sk_out)
  );

  // Address and data travel packed so both halves always leave together.
  assign o_sw_valid = sk_valid;
  assign o_sw_addr = sk_out[SW-1:TWS_DATA_W];
  assign o_sw_data = sk_out[TWS_DATA_W-1:0];
endmodule

// ### verification/tws_sink.sv
// Stream sink for the timed write output that can stall at random.
`timescale 1ns/1ps
module tws_sink (
  // Clock and stall mode
  input wire logic i_ref_clk,
  input wire logic i_slow,
  // Handshake
  output logic o_ready
);
  always_ff @(posedge i_ref_clk) begin
    o_ready <= !i_slow || ($urandom % 4 == 0);
  end
endmodule

// ### verification/tws_top_sva.sv
// Port checker for the timed write sequencer.
`timescale 1ns/1ps
module tws_top_sva (
  // Clock and resets
  input wire logic i_ref_clk, i_nrst, i_por,
  // Queue, direct access and stream
  input wire logic i_q_valid, o_q_ready, o_q_empty, o_seq_busy, i_cr_rd, o_cr_rvalid,
  input wire logic o_sw_valid, i_sw_ready,
  input wire logic [7:0] o_sw_addr, o_sw_data
);
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_nrst || i_por);
  // One record takes three pops before any write can leave.
  sequence s_pops;
    o_seq_busy [*3];
  endsequence
  chk_por_clear: assert property (disable iff (!i_nrst) i_por |=>
    o_q_ready && o_q_empty && !o_seq_busy && !o_sw_valid && !o_cr_rvalid)
    else $error("Power-on reset did not clear state");
  chk_rd_answer: assert property (i_cr_rd |=> o_cr_rvalid)
    else $error("Read not answered");
  chk_rd_cause: assert property (o_cr_rvalid |-> $past(i_cr_rd))
    else $error("Read valid without read");
  chk_sw_hold: assert property (o_sw_valid && !i_sw_ready |=>
    o_sw_valid && $stable({o_sw_addr, o_sw_data})) else $error("Stalled write changed");
  chk_idle_quiet: assert property (o_q_empty && !o_seq_busy && !o_sw_valid
    |=> !o_sw_valid) else $error("Write from an empty queue");
  chk_push_kept: assert property (i_q_valid && o_q_ready |=> !o_q_empty)
    else $error("Accepted byte lost");
  chk_pop_steps: assert property ($rose(o_seq_busy) |-> s_pops)
    else $error("Record parse too short");
  chk_sw_source: assert property ($rose(o_sw_valid) |-> $past(o_seq_busy))
    else $error("Write without a record");
endmodule
bind tws_top tws_top_sva i_chk (.i_ref_clk, .i_nrst, .i_por, .i_q_valid, .o_q_ready,
  .o_q_empty, .o_seq_busy, .i_cr_rd, .o_cr_rvalid, .o_sw_valid, .i_sw_ready, .o_sw_addr,
  .o_sw_data);

// ### verification/tb_top.sv
// Self-checking bench for the timed write sequencer.
`timescale 1ns/1ps
module tb_top;
  import tws_pkg::*;
  localparam int TC = 1;
  logic clk = 1'h0, nrst = 1'h0, por = 1'h0, qv = 1'h0, wr = 1'h0, rd = 1'h0;
  logic slow = 1'h0, full_seen = 1'h0;
  logic [7:0] qd = 8'h00, ad = 8'h00, wd = 8'h00, v;
  logic [7:0] tw[3] = '{8'h00, 8'h01, 8'h07};
  logic q_ready, rvalid, q_empty, busy, sw_valid, sw_ready;
  logic [7:0] rdata, sw_addr, sw_data;
  logic [15:0] exp_q[$];
  int err_total = 0, total_checks = 0, n;
  always #25 clk = !clk;
  tws_top #(.DEPTH(16), .TICK_CYC(TC)) i_dut (.i_ref_clk(clk), .i_nrst(nrst),
    .i_por(por), .i_q_valid(qv), .i_q_data(qd), .o_q_ready(q_ready), .i_cr_wr(wr),
    .i_cr_rd(rd), .i_cr_addr(ad), .i_cr_wdata(wd), .o_cr_rdata(rdata),
    .o_cr_rvalid(rvalid), .o_q_empty(q_empty), .o_seq_busy(busy),
    .o_sw_valid(sw_valid), .i_sw_ready(sw_ready), .o_sw_addr(sw_addr),
    .o_sw_data(sw_data));
  tws_sink i_sink (.i_ref_clk(clk), .i_slow(slow), .o_ready(sw_ready));
  function automatic int min_wait(input logic [7:0] t);
    return 3 + t * TC;
  endfunction
  task automatic cmp_w(input logic [15:0] g, input logic [15:0] e);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // An empty expectation compares against unknown, so a stray word always fails.
  always @(posedge clk) begin
    if (nrst && !por && sw_valid && sw_ready) begin
      cmp_w({sw_addr, sw_data}, exp_q.size() ? exp_q.pop_front() : 16'hxxxx);
    end
    full_seen <= !q_ready || (slow && full_seen);
  end
  task automatic push(input logic [7:0] b);
    qv <= 1'h1;
    qd <= b;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (!q_ready && n < 3000);
  endtask
  task automatic rec(input logic [7:0] t, input logic [7:0] a, input logic [7:0] d);
    push(t);
    push(a);
    push(d);
    exp_q.push_back({a, d});
  endtask
  task automatic host(input logic w, input logic [7:0] a, input logic [7:0] d);
    wr <= w;
    rd <= !w;
    ad <= a;
    wd <= d;
    @(posedge clk);
    wr <= 1'h0;
    rd <= 1'h0;
    @(posedge clk);
    if (!w) cmp_w({rvalid, 7'h0, rdata}, {8'h80, d});
    repeat (2) @(posedge clk);
  endtask
  task automatic rst(input logic p);
    por <= p;
    nrst <= p;
    repeat (5) @(posedge clk);
    por <= 1'h0;
    nrst <= 1'h1;
    exp_q.delete();
    @(posedge clk);
    cmp_w({12'h0, q_empty, q_ready, busy, sw_valid}, 16'h000c);
  endtask
  task automatic drain;
    n = 0;
    while (exp_q.size() > 0 && n < 3000) begin
      @(posedge clk);
      n++;
    end
    @(posedge clk);
    cmp_w({15'h0, q_empty}, 16'h0001);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // The tests need a few hundred cycles, so twenty thousand means a hang.
  initial begin
    #1000000;
    err_total++;
    tally_and_finish;
  end
  initial begin
    void'($urandom(15));
    rst(1'h0);
    push(8'h00);
    push(8'h85);
    qv <= 1'h0;
    repeat (8) @(posedge clk);
    cmp_w({15'h0, sw_valid | busy}, 16'h0000);
    exp_q.push_back(16'h8566);
    push(8'h66);
    qv <= 1'h0;
    drain;
    $display("test partial record done");
    foreach (tw[i]) begin
      rec(tw[i], 8'h90, 8'($urandom));
      qv <= 1'h0;
      n = 0;
      while (!sw_valid && n < 2000) begin
        @(posedge clk);
        n++;
      end
      cmp_w({15'h0, n >= min_wait(tw[i])}, 16'h0001);
      drain;
    end
    $display("test timed wait done");
    slow <= 1'h1;
    repeat (12) rec(8'h0a, 8'($urandom) | 8'hc0, 8'($urandom));
    qv <= 1'h0;
    cmp_w({15'h0, full_seen}, 16'h0001);
    slow <= 1'h0;
    drain;
    $display("test fill and stall done");
    repeat (6) begin
      v = 8'($urandom);
      host(1'h1, v & 8'h7f, ~v);
      host(1'h0, v & 8'h7f, ~v);
    end
    host(1'h0, 8'h85, 8'h66);
    $display("test host access done");
    rec(8'hff, 8'h85, 8'h11);
    qv <= 1'h0;
    rst(1'h1);
    host(1'h0, 8'h85, 8'h00);
    $display("test power-on reset done");
    tally_and_finish;
  end
endmodule
